// ==== core/boot_seq_pkg.sv ====
/*
 * Constants shared by the boot-mode and secure-boot sequencer.
 * Assumes a 32-bit AXI4-Lite register bus and a 10 MHz aclk.
 */
package boot_seq_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] addr_status = 8'h00;
    localparam logic [7:0] addr_control = 8'h04;
    localparam logic [7:0] addr_secure_flag = 8'h08;
    localparam logic [7:0] addr_master_ids = 8'h0C;
    localparam logic [7:0] addr_strap = 8'h10;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int ctrl_init_done_bit = 0;
    localparam int ctrl_app_branch_bit = 1;
    localparam logic [7:0] ctrl_init_done_key = 8'hA5;

    // ****************************************************************
    // Strap encodings
    // ****************************************************************
    localparam logic [2:0] serial_load_config = 3'h4;
    localparam logic [2:0] two_wire_debug_config = 3'h1;
    localparam logic [2:0] four_wire_debug_config = 3'h0;

    // ****************************************************************
    // Reset values and identifiers
    // ****************************************************************
    localparam logic [3:0] init_cpu_id = 4'h1;
    localparam logic [3:0] init_dma_id = 4'h2;
    localparam logic [3:0] app_cpu_id = 4'h5;
    localparam logic [3:0] app_dma_id = 4'h6;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int clk_period_ns = 100;
    localparam int self_reset_ns = 800;
    localparam int self_reset_cycles = (self_reset_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int strap_settle_cycles = 4;

    typedef enum logic [2:0] {
        st_sense = 3'b000,
        st_early_rom = 3'b001,
        st_init_boot = 3'b010,
        st_self_reset = 3'b011,
        st_app_boot = 3'b100,
        st_application = 3'b101
    } boot_state_type;

    typedef enum logic [1:0] {
        mode_four_wire = 2'b00,
        mode_two_wire = 2'b01,
        mode_serial_load = 2'b10,
        mode_reserved = 2'b11
    } boot_mode_type;

endpackage : boot_seq_pkg

// ==== core/strap_sync.sv ====
/*
 * Three-stage synchroniser for the strap pins.
 * Assumes the straps are static levels during power-up.
 */
`timescale 1ns/10ps
`default_nettype none
module strap_sync #(
    parameter int width = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [width-1:0] pins,
    output logic [width-1:0] level,
    output logic stable
);
    typedef struct packed {
        logic [width-1:0] s1;
        logic [width-1:0] s2;
        logic [width-1:0] s3;
    } sync_state_type;

    sync_state_type state_reg;
    sync_state_type state_next;

    always_comb begin
        state_next = state_reg;
        state_next.s1 = pins;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.s3;
    assign stable = (state_reg.s2 == state_reg.s3);
endmodule : strap_sync
`default_nettype wire

// ==== core/boot_sequencer.sv ====
/*
 * Boot-mode and secure-boot sequencer with an AXI4-Lite register slave.
 * Assumes aresetn is the power-on reset and boot software drives control.
 */
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Power-on reset sets the init-boot flag.
// - Secure registers are accessible only during init boot.
// - Early ROM step checks the flag to pick first or second boot.
// - Flag set means the init boot code runs.
// - Init completion clears the flag and swaps cpu and dma master IDs; the code loads app_cpu_id and app_dma_id instead of swapping.
// - After clearing the flag a self reset starts the second boot.
// - Second boot sees flag clear and the application master ID.
// - After early ROM and non-secure boot, branch to the application.
// - Until power cycle, processor stays application role, secure locked.
// - Straps sampled at power-up and latched before reset release.
// - Latched straps pick default debug and serial pin mapping.
// - Strap 100 selects serial load mode.
// - Serial load waits forever with four-wire debug; board changes straps.
// - Strap 001 selects two-wire debug, clock and mode-select only.
// - Strap 000 selects four-wire debug with all four signals.
module boot_sequencer
    import boot_seq_pkg::*;
#(
    parameter int strap_width = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [strap_width-1:0] boot_strap_pins,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic cpu_reset_n,
    output logic boot_done,
    output logic [1:0] boot_mode,
    output logic serial_load_mode,
    output logic functional_four_wire_debug_mode,
    output logic functional_two_wire_debug_mode,
    output logic [3:0] debug_pin_enable,
    output logic uart0_load_enable,
    output logic [3:0] cpu_master_id,
    output logic [3:0] dma_master_id,
    output logic secure_access_allowed
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        boot_state_type fsm;
        logic [3:0] count;
        logic init_flag;
        logic [strap_width-1:0] strap;
        logic strap_latched;
        logic [1:0] mode;
        logic [3:0] cpu_id;
        logic [3:0] dma_id;
        logic second_boot;
        logic [31:0] scratch;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [3:0] cpu_rst_cnt;
        logic run;
        logic done;
        logic secure;
        logic serial;
        logic four;
        logic two;
        logic [3:0] pin_en;
    } seq_state_type;

    seq_state_type state_reg;
    seq_state_type state_next;

    logic [strap_width-1:0] strap_level;
    logic strap_stable;

    strap_sync #(
        .width(strap_width)
    ) u_strap_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins(boot_strap_pins),
        .level(strap_level),
        .stable(strap_stable)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [1:0] decode_mode(input logic [2:0] s);
        case (s)
            serial_load_config: decode_mode = mode_serial_load;
            two_wire_debug_config: decode_mode = mode_two_wire;
            four_wire_debug_config: decode_mode = mode_four_wire;
            default: decode_mode = mode_reserved;
        endcase
    endfunction : decode_mode

    function automatic logic is_secure(input logic [7:0] a);
        is_secure = (a == addr_secure_flag) || (a == addr_master_ids);
    endfunction : is_secure

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    logic secure_ok;
    logic do_write;
    logic do_read;
    logic init_done_cmd;
    logic app_branch_cmd;

    assign secure_ok = state_reg.init_flag && (state_reg.fsm == st_init_boot);
    assign do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    assign do_read = s_axi_arvalid && !state_reg.rvalid;
    assign init_done_cmd = do_write && (state_reg.aw_addr == addr_control)
                           && state_reg.w_strb[0] && state_reg.w_data[7:0] == ctrl_init_done_key;
    assign app_branch_cmd = do_write && (state_reg.aw_addr == addr_control)
                            && state_reg.w_strb[1] && state_reg.w_data[8 + ctrl_app_branch_bit];

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [31:0] rd;
        logic [1:0] rr;
        rd = 32'h0000_0000;
        rr = 2'b00;
        state_next = state_reg;

        // Bus address and data capture
        if (s_axi_awvalid && !state_reg.aw_held) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.w_held) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end

        // Write
        if (do_write) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = 2'b00;
            case (state_reg.aw_addr)
                addr_control: begin
                end
                addr_secure_flag, addr_master_ids: begin
                    if (!secure_ok) begin
                        state_next.bresp = 2'b10;
                    end else begin
                        state_next.scratch = merge(state_reg.scratch, state_reg.w_data,
                                                   state_reg.w_strb);
                    end
                end
                addr_status, addr_strap: begin
                end
                default: state_next.bresp = 2'b11;
            endcase
        end

        // Read
        if (do_read) begin
            case (s_axi_araddr)
                addr_status: begin
                    rd = {21'h00_0000, state_reg.second_boot, state_reg.mode,
                          state_reg.init_flag, state_reg.strap_latched, state_reg.fsm,
                          1'b0, cpu_reset_n, boot_done};
                end
                addr_control: rd = 32'h0000_0000;
                addr_strap: rd = {29'h0000_0000, state_reg.strap};
                addr_secure_flag: begin
                    if (secure_ok) begin
                        rd = {31'h0000_0000, state_reg.init_flag};
                    end else begin
                        rr = 2'b10;
                    end
                end
                addr_master_ids: begin
                    if (secure_ok) begin
                        rd = {24'h00_0000, state_reg.dma_id, state_reg.cpu_id};
                    end else begin
                        rr = 2'b10;
                    end
                end
                default: rr = 2'b11;
            endcase
            state_next.rvalid = 1'b1;
            state_next.rdata = rd;
            state_next.rresp = rr;
        end

        if (state_reg.cpu_rst_cnt != 4'h0) begin
            state_next.cpu_rst_cnt = state_reg.cpu_rst_cnt - 4'h1;
        end

        // Boot sequence
        case (state_reg.fsm)
            st_sense: begin
                if (strap_stable) begin
                    state_next.count = state_reg.count + 4'h1;
                end else begin
                    state_next.count = 4'h0;
                end
                if (state_reg.count == 4'(strap_settle_cycles)) begin
                    state_next.strap = strap_level;
                    state_next.mode = decode_mode(strap_level);
                    state_next.strap_latched = 1'b1;
                    state_next.fsm = st_early_rom;
                    state_next.count = 4'h0;
                end
            end
            st_early_rom: begin
                if (state_reg.mode == mode_serial_load) begin
                    state_next.fsm = st_early_rom;
                end else if (state_reg.init_flag) begin
                    state_next.fsm = st_init_boot;
                end else begin
                    state_next.fsm = st_app_boot;
                end
            end
            st_init_boot: begin
                if (init_done_cmd) begin
                    state_next.init_flag = 1'b0;
                    state_next.cpu_id = app_cpu_id;
                    state_next.dma_id = app_dma_id;
                    state_next.cpu_rst_cnt = 4'(self_reset_cycles);
                    state_next.fsm = st_self_reset;
                end
            end
            st_self_reset: begin
                if (state_reg.cpu_rst_cnt == 4'h1) begin
                    state_next.second_boot = 1'b1;
                    state_next.fsm = st_early_rom;
                end
            end
            st_app_boot: begin
                if (app_branch_cmd) begin
                    state_next.fsm = st_application;
                end
            end
            st_application: begin
                state_next.fsm = st_application;
            end
            default: state_next.fsm = st_sense;
        endcase

        // Registered decodes of the next state
        state_next.run = state_next.strap_latched && (state_next.cpu_rst_cnt == 4'h0);
        state_next.done = (state_next.fsm == st_application);
        state_next.secure = state_next.init_flag && (state_next.fsm == st_init_boot);
        state_next.serial = (state_next.mode == mode_serial_load);
        state_next.four = (state_next.mode == mode_four_wire);
        state_next.two = (state_next.mode == mode_two_wire);
        case (state_next.mode)
            mode_two_wire: state_next.pin_en = 4'h6;
            mode_reserved: state_next.pin_en = 4'h0;
            default: state_next.pin_en = 4'hf;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
            state_reg.fsm <= st_sense;
            state_reg.init_flag <= 1'b1;
            state_reg.cpu_id <= init_cpu_id;
            state_reg.dma_id <= init_dma_id;
            state_reg.mode <= mode_four_wire;
            state_reg.four <= 1'b1;
            state_reg.pin_en <= 4'hf;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = !state_reg.aw_held;
    assign s_axi_wready = !state_reg.w_held;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    assign cpu_reset_n = state_reg.run;
    assign boot_done = state_reg.done;
    assign boot_mode = state_reg.mode;
    assign serial_load_mode = state_reg.serial;
    assign functional_four_wire_debug_mode = state_reg.four;
    assign functional_two_wire_debug_mode = state_reg.two;
    assign debug_pin_enable = state_reg.pin_en;
    assign uart0_load_enable = state_reg.serial;
    assign cpu_master_id = state_reg.cpu_id;
    assign dma_master_id = state_reg.dma_id;
    assign secure_access_allowed = state_reg.secure;

endmodule : boot_sequencer
`default_nettype wire

// ==== sim/strap_board.sv ====
/*
 * Board model: strap resistors, plus later use of strap bit two as an output.
 * Assumes the bench picks the strap value before each power-on reset.
 */
`timescale 1ns/10ps
`default_nettype none
module strap_board (
    input wire logic aclk,
    input wire logic [2:0] strap_choice,
    input wire logic app_up,
    output logic [2:0] boot_strap_pins
);
    logic bit_two_out = 1'h0;

    // Bit two toggles as an output once the application runs
    always @(posedge aclk) begin
        bit_two_out <= app_up ? ~bit_two_out : 1'h0;
    end

    // Strap bit two follows bit_two_out while app_up is set; otherwise the pins hold strap_choice
    assign boot_strap_pins = app_up ? {bit_two_out, strap_choice[1:0]} : strap_choice;
endmodule : strap_board
`default_nettype wire

// ==== sim/boot_sequencer_asserts.sv ====
/*
 * Concurrent checks on the boot sequencer ports.
 * Assumes aclk and the synchronous active-low aresetn of the design.
 */
`timescale 1ns/10ps
`default_nettype none
module boot_sequencer_asserts
    import boot_seq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic cpu_reset_n,
    input wire logic boot_done,
    input wire logic [1:0] boot_mode,
    input wire logic serial_load_mode,
    input wire logic functional_four_wire_debug_mode,
    input wire logic functional_two_wire_debug_mode,
    input wire logic [3:0] debug_pin_enable,
    input wire logic uart0_load_enable,
    input wire logic [3:0] cpu_master_id,
    input wire logic [3:0] dma_master_id,
    input wire logic secure_access_allowed
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_init_ids;
        secure_access_allowed |-> cpu_master_id == init_cpu_id && dma_master_id == init_dma_id;
    endproperty
    a_init_ids: assert property (p_init_ids) else $error("ids wrong in init boot");
    property p_self_reset;
        $fell(secure_access_allowed) |-> ##[0:2] !cpu_reset_n;
    endproperty
    a_self_reset: assert property (p_self_reset) else $error("no self reset");
    property p_done;
        boot_done |-> cpu_reset_n && !secure_access_allowed && cpu_master_id == app_cpu_id;
    endproperty
    a_done: assert property (p_done) else $error("application role wrong");
    property p_app_hold;
        cpu_master_id == app_cpu_id |=> cpu_master_id == app_cpu_id && !secure_access_allowed;
    endproperty
    a_app_hold: assert property (p_app_hold) else $error("application id lost");
    property p_refused;
        s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000 && !secure_access_allowed;
    endproperty
    a_refused: assert property (p_refused) else $error("secure refusal wrong");
    property p_two;
        functional_two_wire_debug_mode |-> debug_pin_enable == 4'h6 && boot_mode == mode_two_wire;
    endproperty
    a_two: assert property (p_two) else $error("two wire pins wrong");
    property p_four;
        functional_four_wire_debug_mode |-> debug_pin_enable == 4'hf;
    endproperty
    a_four: assert property (p_four) else $error("four wire pins wrong");
    property p_serial;
        serial_load_mode |-> uart0_load_enable && debug_pin_enable == 4'hf && !boot_done;
    endproperty
    a_serial: assert property (p_serial) else $error("serial load wrong");
    property p_mode_hold;
        cpu_reset_n |=> $stable(boot_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
endmodule : boot_sequencer_asserts

bind boot_sequencer boot_sequencer_asserts boot_sequencer_asserts_i (.*);
`default_nettype wire

// ==== sim/boot_sequencer_bench.sv ====
/*
 * Self-checking bench for the boot sequencer.
 * Assumes the strap_board partner and an AXI4-Lite master made of tasks.
 */
`timescale 1ns/10ps
`default_nettype none
module boot_sequencer_bench
    import boot_seq_pkg::*;
;
    logic aclk = 0, aresetn = 0, app_up = 0;
    logic [2:0] strap_choice = 0;
    wire logic [2:0] boot_strap_pins;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0, debug_pin_enable, cpu_master_id, dma_master_id;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, cpu_reset_n, boot_done, serial_load_mode, uart0_load_enable;
    logic functional_four_wire_debug_mode, functional_two_wire_debug_mode, secure_access_allowed;
    logic [1:0] s_axi_bresp, s_axi_rresp, boot_mode;
    int n_errors = 0, samples_checked = 0, low_run = 0, last_low = 0;

    boot_sequencer boot_sequencer_i (.*);
    strap_board strap_board_i (.aclk(aclk), .strap_choice(strap_choice), .app_up(app_up),
        .boot_strap_pins(boot_strap_pins));

    initial begin
        forever #50 aclk = ~aclk;
    end
    // Length of each processor reset pulse
    always @(negedge aclk) begin
        if (!cpu_reset_n) low_run++;
        else if (low_run != 0) begin
            last_low = low_run;
            low_run = 0;
        end
    end

    // ****************************************************************
    // Bus and check tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] d, output logic [1:0] r);
        bit ta, tw, tr, done;
        done = 0;
        @(posedge aclk);
        if (w) begin
            s_axi_awaddr <= a; s_axi_wdata <= wd; s_axi_wstrb <= 4'hf;
            s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        end else begin
            s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        end
        while (!done) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            done = w ? s_axi_bvalid : s_axi_rvalid;
            r = w ? s_axi_bresp : s_axi_rresp;
            d = s_axi_rdata;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            if (tr) s_axi_arvalid <= 0;
            if (done) begin
                s_axi_bready <= 0; s_axi_rready <= 0;
            end
        end
        chk("response", 1, done);
    endtask : bus

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        bus(0, a, 0, d, r);
        chk(nm, e, d & m);
        chk("rresp", er, r);
    endtask : rdchk

    task automatic power_on(input logic [2:0] s);
        @(posedge aclk);
        aresetn <= 0; app_up <= 0; strap_choice <= s;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        for (int n = 0; n < 40 && cpu_reset_n !== 1; n++) @(negedge aclk);
        chk("cpu_reset_n", 1, cpu_reset_n);
    endtask : power_on

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_boot_flow;
        logic [31:0] d;
        logic [1:0] r;
        power_on(four_wire_debug_config);
        chk("debug_pin_enable", 4'hf, debug_pin_enable);
        chk("four_wire_mode", 1, functional_four_wire_debug_mode);
        for (int n = 0; n < 40 && secure_access_allowed !== 1; n++) @(negedge aclk);
        chk("secure_access_allowed", 1, secure_access_allowed);
        rdchk("status flag", addr_status, 32'h0000_0080, 32'h0000_0080, 2'h0);
        rdchk("ids", addr_master_ids, 32'h0000_00ff, {init_dma_id, init_cpu_id}, 2'h0);
        bus(1, addr_control, 32'h0000_00a5, d, r);
        chk("init bresp", 2'h0, r);
        for (int n = 0; n < 10 && cpu_reset_n !== 0; n++) @(negedge aclk);
        for (int n = 0; n < 20 && cpu_reset_n !== 1; n++) @(negedge aclk);
        @(posedge aclk);
        chk("self reset length", self_reset_cycles, last_low);
        chk("cpu id", app_cpu_id, cpu_master_id);
        chk("dma id", app_dma_id, dma_master_id);
        rdchk("status second", addr_status, 32'h0000_0480, 32'h0000_0400, 2'h0);
        rdchk("secure read", addr_secure_flag, 32'hffff_ffff, 0, 2'h2);
        bus(1, addr_master_ids, 32'h0000_0021, d, r);
        chk("secure bresp", 2'h2, r);
        rdchk("unmapped", 8'h14, 32'hffff_ffff, 0, 2'h3);
        bus(1, addr_control, 32'h0000_0200, d, r);
        for (int n = 0; n < 20 && boot_done !== 1; n++) @(negedge aclk);
        chk("boot_done", 1, boot_done);
        chk("cpu id kept", app_cpu_id, cpu_master_id);
        chk("secure locked", 0, secure_access_allowed);
    endtask : test_boot_flow

    task automatic test_two_wire;
        power_on(two_wire_debug_config);
        chk("debug_pin_enable", 4'h6, debug_pin_enable);
        chk("two_wire_mode", 1, functional_two_wire_debug_mode);
        rdchk("strap", addr_strap, 32'h0000_0007, 32'h0000_0001, 2'h0);
        app_up <= 1;
        repeat (10) @(posedge aclk);
        chk("boot_mode", mode_two_wire, boot_mode);
        app_up <= 0;
    endtask : test_two_wire

    task automatic test_serial;
        power_on(serial_load_config);
        chk("uart0_load_enable", 1, uart0_load_enable);
        chk("serial_load_mode", 1, serial_load_mode);
        chk("debug_pin_enable", 4'hf, debug_pin_enable);
        repeat (50) @(negedge aclk);
        chk("boot_done", 0, boot_done);
        rdchk("fsm", addr_status, 32'h0000_0038, 32'h0000_0008, 2'h0);
        power_on(four_wire_debug_config);
        chk("boot_mode", mode_four_wire, boot_mode);
    endtask : test_serial

    task automatic test_reserved;
        power_on(3'h2);
        chk("debug_pin_enable", 4'h0, debug_pin_enable);
        chk("boot_mode", mode_reserved, boot_mode);
    endtask : test_reserved

    task automatic print_verdict;
        if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    initial begin
        #(100 * 20000);
        n_errors++;
        print_verdict();
    end

    initial begin
        test_boot_flow();
        test_two_wire();
        test_serial();
        test_reserved();
        print_verdict();
    end
endmodule : boot_sequencer_bench
`default_nettype wire
